// >>> shared/bifurcation_defines.svh
// constants for the graphics port bifurcation configuration block
`ifndef BIFURCATION_DEFINES_SVH
`define BIFURCATION_DEFINES_SVH
`define LANE_COUNT        16
`define HALF_LANES        8
`define PRI_FIRST_LANE    0
`define SEC_FIRST_LANE    8
`define SETTLE_COUNT      3'h4
`define STRAP_ASSERTED    1'h0
`define STRAP_DEASSERTED  1'h1
`define LANE_OWNER_NONE   2'h0
`define LANE_OWNER_PRI    2'h1
`define LANE_OWNER_SEC    2'h2
`endif

// >>> shared/bifurcation_pkg.sv
// types for the graphics port bifurcation configuration block
package bifurcation_pkg;
   typedef enum logic [1:0] {
      cfg_none_type_v,
      cfg_single16_type_v,
      cfg_dual8_type_v,
      cfg_secondary_only_type_v
   } port_cfg_type;
endpackage : bifurcation_pkg

// >>> verilog/strap_sync.sv
// three-stage strap synchroniser with agreement filter
`timescale 1ns/1ps
`include "bifurcation_defines.svh"
module strap_sync (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic clk_en,
   // pin side
   input  wire logic pin_in,
   // filtered level
   output logic      level_ff
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   wire  agree = (s2_ff == s3_ff);
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s1_ff    <= `STRAP_DEASSERTED;
         s2_ff    <= `STRAP_DEASSERTED;
         s3_ff    <= `STRAP_DEASSERTED;
         level_ff <= `STRAP_DEASSERTED;
      end else if (clk_en) begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (agree) begin
            level_ff <= s3_ff;
         end
      end
   end
endmodule : strap_sync

// >>> verilog/graphics_port_bifurcation_config.sv
// strap-driven lane and port-function configuration for the graphics ports
`timescale 1ns/1ps
`include "bifurcation_defines.svh"
module graphics_port_bifurcation_config #(
   parameter int LANES = `LANE_COUNT
) (
   // clock, reset, enable
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire logic                clk_en,
   // board straps
   input  wire logic                dual_port_enable_strap_n,
   input  wire logic                primary_slot_present_strap_n,
   input  wire logic                lane_reversal_strap,
   // firmware enable controls
   input  wire logic                pri_fn_enable,
   input  wire logic                sec_fn_enable_wr,
   input  wire logic                sec_fn_enable_wdata,
   // configuration status
   output logic                     straps_valid_ff,
   output logic [1:0]               port_cfg_ff,
   output logic                     unsupported_cfg_ff,
   output logic                     sec_fn_enable_ff,
   // link control for each bridge function
   output logic                     pri_link_train_en_ff,
   output logic                     sec_link_train_en_ff,
   output logic                     pri_clk_run_ff,
   output logic                     sec_clk_run_ff,
   output logic [LANES-1:0]         pri_lane_mask_ff,
   output logic [LANES-1:0]         sec_lane_mask_ff,
   output logic [LANES*4-1:0]       phys_to_logical_ff,
   output logic [LANES*2-1:0]       phys_owner_ff
);
   // filtered strap levels
   logic dual_lvl;
   logic pri_lvl;
   logic rev_lvl;

   strap_sync u_sync_dual (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clk_en   (clk_en),
      .pin_in   (dual_port_enable_strap_n),
      .level_ff (dual_lvl)
   );
   strap_sync u_sync_pri (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clk_en   (clk_en),
      .pin_in   (primary_slot_present_strap_n),
      .level_ff (pri_lvl)
   );
   strap_sync u_sync_rev (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clk_en   (clk_en),
      .pin_in   (lane_reversal_strap),
      .level_ff (rev_lvl)
   );

   // latch straps once after the synchroniser has settled
   logic [2:0] settle_ff;
   logic       dual_n_ff;
   logic       pri_n_ff;
   logic       rev_ff;
   wire        settled = (settle_ff == `SETTLE_COUNT);
   wire        capture = settled && !straps_valid_ff;
   wire [2:0]  nxt_settle = settle_ff + 3'h1;

   // settle counter stops once it reaches its limit
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         settle_ff <= 3'h0;
      end else if (clk_en && !settled) begin
         settle_ff <= nxt_settle;
      end
   end

   // straps are taken once; later changes, such as a card pulled live, are ignored
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         straps_valid_ff <= 1'h0;
         dual_n_ff       <= `STRAP_DEASSERTED;
         pri_n_ff        <= `STRAP_DEASSERTED;
         rev_ff          <= 1'h0;
      end else if (clk_en && capture) begin
         dual_n_ff       <= dual_lvl;
         pri_n_ff        <= pri_lvl;
         rev_ff          <= rev_lvl;
         straps_valid_ff <= 1'h1;
      end
   end

   // strap decode, low means card present
   wire dual_present = (dual_n_ff == `STRAP_ASSERTED);
   wire pri_present  = (pri_n_ff == `STRAP_ASSERTED);
   wire is_dual      = dual_present && pri_present;
   wire is_single16  = !dual_present && pri_present;
   wire is_sec_only  = dual_present && !pri_present;
   wire is_none      = !dual_present && !pri_present;

   bifurcation_pkg::port_cfg_type cfg_sel;
   assign cfg_sel = is_dual     ? bifurcation_pkg::cfg_dual8_type_v :
                    is_single16 ? bifurcation_pkg::cfg_single16_type_v :
                    is_sec_only ? bifurcation_pkg::cfg_secondary_only_type_v :
                                  bifurcation_pkg::cfg_none_type_v;

   // secondary enable bit: strap default, then firmware writable
   // at capture the latched copy still holds its reset value, so read the filtered level
   wire nxt_sec_en = capture ? (dual_lvl == `STRAP_ASSERTED) :
                     (sec_fn_enable_wr && straps_valid_ff) ? sec_fn_enable_wdata :
                     sec_fn_enable_ff;

   // link training permission per function
   wire pri_train = straps_valid_ff && pri_fn_enable && (is_dual || is_single16);
   wire sec_train = straps_valid_ff && sec_fn_enable_ff && (is_dual || is_sec_only);

   // logical lane ownership before reversal
   logic [LANES-1:0]   pri_logical;
   logic [LANES-1:0]   sec_logical;
   // next values and reset image of the per-lane outputs
   logic [LANES-1:0]   nxt_pri_mask;
   logic [LANES-1:0]   nxt_sec_mask;
   logic [LANES*4-1:0] nxt_phys_to_logical;
   logic [LANES*2-1:0] nxt_phys_owner;
   logic [LANES*4-1:0] identity_map;
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         localparam logic [3:0] LOG_IDX = 4'(g);
         localparam logic [3:0] REV_IDX = 4'(LANES - 1 - g);
         wire lower = (g < `SEC_FIRST_LANE);
         assign pri_logical[g] = pri_train && (is_single16 || lower);
         assign sec_logical[g] = sec_train && !lower;
         // physical lane g carries logical lane REV_IDX under reversal
         wire [3:0] map_idx = rev_ff ? REV_IDX : LOG_IDX;
         // owner is looked up by logical lane, so control moves with the lanes
         wire own_pri = pri_logical[map_idx];
         wire own_sec = sec_logical[map_idx];
         wire [1:0] owner = own_pri ? `LANE_OWNER_PRI :
                            own_sec ? `LANE_OWNER_SEC : `LANE_OWNER_NONE;
         assign identity_map[g*4 +: 4]        = LOG_IDX;
         assign nxt_phys_to_logical[g*4 +: 4] = map_idx;
         assign nxt_phys_owner[g*2 +: 2]      = owner;
         assign nxt_pri_mask[g]               = own_pri;
         assign nxt_sec_mask[g]               = own_sec;
      end
   endgenerate

   // per-lane outputs, all lanes in one register stage
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phys_to_logical_ff <= identity_map;
         phys_owner_ff      <= '0;
         pri_lane_mask_ff   <= '0;
         sec_lane_mask_ff   <= '0;
      end else if (clk_en) begin
         phys_to_logical_ff <= nxt_phys_to_logical;
         phys_owner_ff      <= nxt_phys_owner;
         pri_lane_mask_ff   <= nxt_pri_mask;
         sec_lane_mask_ff   <= nxt_sec_mask;
      end
   end

   // next values of the status and control registers, one bridge function per link
   bifurcation_pkg::port_cfg_type nxt_port_cfg;
   assign nxt_port_cfg = straps_valid_ff ? cfg_sel : bifurcation_pkg::cfg_none_type_v;
   wire nxt_unsupported = straps_valid_ff && is_sec_only;
   // primary clock follows its function enable, and stops when firmware clears it
   wire nxt_pri_clk     = pri_fn_enable;

   // configuration status
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         port_cfg_ff        <= bifurcation_pkg::cfg_none_type_v;
         unsupported_cfg_ff <= 1'h0;
         sec_fn_enable_ff   <= 1'h0;
      end else if (clk_en) begin
         port_cfg_ff        <= nxt_port_cfg;
         unsupported_cfg_ff <= nxt_unsupported;
         sec_fn_enable_ff   <= nxt_sec_en;
      end
   end

   // link training permission for each bridge function
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pri_link_train_en_ff <= 1'h0;
         sec_link_train_en_ff <= 1'h0;
      end else if (clk_en) begin
         pri_link_train_en_ff <= pri_train;
         sec_link_train_en_ff <= sec_train;
      end
   end

   // clock run controls; the secondary clock is gated off together with its enable bit
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pri_clk_run_ff <= 1'h0;
         sec_clk_run_ff <= 1'h0;
      end else if (clk_en) begin
         pri_clk_run_ff <= nxt_pri_clk;
         sec_clk_run_ff <= nxt_sec_en;
      end
   end
endmodule : graphics_port_bifurcation_config

// >>> sim/card_slots.sv
// add-in card slot model driving the two present-detect straps
`timescale 1ns/1ps
module card_slots (
   // cards fitted
   input  wire logic pri_card,
   input  wire logic sec_card,
   // present-detect lines, pulled up when the slot is empty
   output logic      pri_present_n,
   output logic      sec_present_n
);
   assign pri_present_n = pri_card ? 1'h0 : 1'h1;
   assign sec_present_n = sec_card ? 1'h0 : 1'h1;
endmodule : card_slots

// >>> sim/bifurcation_checker.sv
// assertion checker for the graphics port bifurcation block
`timescale 1ns/1ps
module bifurcation_checker #(
   parameter int LANES = 16
) (
   // clock, reset and inputs
   input wire logic               clk_sys,
   input wire logic               rst,
   input wire logic               clk_en,
   input wire logic               pri_fn_enable,
   input wire logic               sec_fn_enable_wr,
   input wire logic               sec_fn_enable_wdata,
   // status and link control
   input wire logic               straps_valid_ff,
   input wire logic [1:0]         port_cfg_ff,
   input wire logic               unsupported_cfg_ff,
   input wire logic               sec_fn_enable_ff,
   input wire logic               pri_link_train_en_ff,
   input wire logic               sec_link_train_en_ff,
   input wire logic               pri_clk_run_ff,
   input wire logic               sec_clk_run_ff,
   // lane ownership
   input wire logic [LANES-1:0]   pri_lane_mask_ff,
   input wire logic [LANES-1:0]   sec_lane_mask_ff,
   input wire logic [LANES*2-1:0] phys_owner_ff
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sec_clk_gate_a: assert property (sec_clk_run_ff == sec_fn_enable_ff) else $error("sec clock mismatch");
   pri_clk_a: assert property (clk_en |=> pri_clk_run_ff == $past(pri_fn_enable))
      else $error("pri clock mismatch");
   valid_hold_a: assert property (straps_valid_ff |=> straps_valid_ff) else $error("valid dropped");
   cfg_static_a: assert property ($past(straps_valid_ff, 2) |-> $stable(port_cfg_ff))
      else $error("config changed");
   sec_only_a: assert property (port_cfg_ff == 2'h3 |-> !pri_link_train_en_ff && unsupported_cfg_ff)
      else $error("secondary-only wrong");
   no_cards_a: assert property (port_cfg_ff == 2'h0 |-> !pri_link_train_en_ff && !sec_link_train_en_ff
      && phys_owner_ff == '0) else $error("empty slots wrong");
   single_a: assert property (port_cfg_ff == 2'h1 |-> !sec_link_train_en_ff && sec_lane_mask_ff == '0)
      else $error("single port wrong");
   masks_apart_a: assert property ((pri_lane_mask_ff & sec_lane_mask_ff) == '0) else $error("lane overlap");
   sec_write_a: assert property (straps_valid_ff && clk_en && sec_fn_enable_wr |=>
      sec_fn_enable_ff == $past(sec_fn_enable_wdata)) else $error("write lost");
   sec_off_a: assert property (clk_en && !sec_fn_enable_ff |=> sec_lane_mask_ff == '0 && !sec_link_train_en_ff)
      else $error("sec lanes live");
   dual_c: cover property (port_cfg_ff == 2'h2);
   sec_only_c: cover property (port_cfg_ff == 2'h3);
   write_c: cover property (straps_valid_ff && sec_fn_enable_wr);
   single_c: cover property (port_cfg_ff == 2'h1);
   sec_off_c: cover property (port_cfg_ff == 2'h2 && !sec_fn_enable_ff);
endmodule : bifurcation_checker
bind graphics_port_bifurcation_config bifurcation_checker #(.LANES(LANES)) checker_i (
   .clk_sys              (clk_sys),
   .rst                  (rst),
   .clk_en               (clk_en),
   .pri_fn_enable        (pri_fn_enable),
   .sec_fn_enable_wr     (sec_fn_enable_wr),
   .sec_fn_enable_wdata  (sec_fn_enable_wdata),
   .straps_valid_ff      (straps_valid_ff),
   .port_cfg_ff          (port_cfg_ff),
   .unsupported_cfg_ff   (unsupported_cfg_ff),
   .sec_fn_enable_ff     (sec_fn_enable_ff),
   .pri_link_train_en_ff (pri_link_train_en_ff),
   .sec_link_train_en_ff (sec_link_train_en_ff),
   .pri_clk_run_ff       (pri_clk_run_ff),
   .sec_clk_run_ff       (sec_clk_run_ff),
   .pri_lane_mask_ff     (pri_lane_mask_ff),
   .sec_lane_mask_ff     (sec_lane_mask_ff),
   .phys_owner_ff        (phys_owner_ff)
);

// >>> sim/graphics_port_bifurcation_config_tb.sv
// self-checking testbench for the graphics port bifurcation block
`timescale 1ns/1ps
module graphics_port_bifurcation_config_tb;
   logic clk_sys, rst, clk_en, pri_card, sec_card, lane_rev, pri_en, wr, wd, pri_n, sec_n;
   logic straps_valid_ff, unsupported_cfg_ff, sec_fn_enable_ff, pri_link_train_en_ff, sec_link_train_en_ff;
   logic pri_clk_run_ff, sec_clk_run_ff;
   logic [1:0]  port_cfg_ff;
   logic [15:0] pri_lane_mask_ff, sec_lane_mask_ff;
   logic [63:0] phys_to_logical_ff;
   logic [31:0] phys_owner_ff;
   int          failures, compares;
   card_slots slots (.pri_card(pri_card), .sec_card(sec_card), .pri_present_n(pri_n), .sec_present_n(sec_n));
   graphics_port_bifurcation_config dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
      .dual_port_enable_strap_n(sec_n), .primary_slot_present_strap_n(pri_n), .lane_reversal_strap(lane_rev),
      .pri_fn_enable(pri_en), .sec_fn_enable_wr(wr), .sec_fn_enable_wdata(wd), .straps_valid_ff(straps_valid_ff),
      .port_cfg_ff(port_cfg_ff), .unsupported_cfg_ff(unsupported_cfg_ff), .sec_fn_enable_ff(sec_fn_enable_ff),
      .pri_link_train_en_ff(pri_link_train_en_ff), .sec_link_train_en_ff(sec_link_train_en_ff),
      .pri_clk_run_ff(pri_clk_run_ff), .sec_clk_run_ff(sec_clk_run_ff), .pri_lane_mask_ff(pri_lane_mask_ff),
      .sec_lane_mask_ff(sec_lane_mask_ff), .phys_to_logical_ff(phys_to_logical_ff), .phys_owner_ff(phys_owner_ff));
   task automatic end_of_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic run_case(input logic pc, input logic sc, input logic rv, input logic [1:0] cfg);
      logic [15:0] pm, sm;
      logic [63:0] map;
      logic [31:0] ow;
      int          l;
      pm = '0;
      sm = '0;
      map = '0;
      ow = '0;
      for (int g = 0; g < 16; g++) begin
         l = rv ? 15 - g : g;
         map[g*4+:4] = l[3:0];
         if (cfg == 2'h1 || (cfg == 2'h2 && l < 8)) pm[g] = 1'b1;
         if (cfg[1] && l >= 8) sm[g] = 1'b1;
         ow[g*2+:2] = pm[g] ? 2'h1 : (sm[g] ? 2'h2 : 2'h0);
      end
      rst = 1'b1;
      pri_card = pc;
      sec_card = sc;
      lane_rev = rv;
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      wr = 1'b1;
      wd = 1'b1;
      @(negedge clk_sys);
      wr = 1'b0;
      for (int i = 0; i < 20 && straps_valid_ff !== 1'b1; i++) @(negedge clk_sys);
      if (straps_valid_ff !== 1'b1) begin
         failures++;
         end_of_test();
      end
      @(negedge clk_sys);
      chk(port_cfg_ff, cfg);
      chk(sec_fn_enable_ff, sc);
      chk(pri_lane_mask_ff, pm);
      chk(sec_lane_mask_ff, sm);
      chk(phys_to_logical_ff, map);
      chk(unsupported_cfg_ff, cfg == 2'h3);
      chk(pri_link_train_en_ff, cfg == 2'h1 || cfg == 2'h2);
      chk(sec_link_train_en_ff, cfg[1]);
      chk(phys_owner_ff, ow);
      chk(sec_clk_run_ff, sc);
      chk(pri_clk_run_ff, 1'b1);
      pri_card = ~pc;
      sec_card = ~sc;
      repeat (8) @(negedge clk_sys);
      chk(port_cfg_ff, cfg);
      chk(pri_lane_mask_ff, pm);
      chk(sec_fn_enable_ff, sc);
   endtask : run_case
   task automatic test_straps();
      for (int i = 0; i < 8; i++) begin
         run_case(i[0], i[1], i[2], i[1] ? (i[0] ? 2'h2 : 2'h3) : (i[0] ? 2'h1 : 2'h0));
      end
      $display("test_straps done");
   endtask : test_straps
   task automatic test_sec_write();
      run_case(1'b1, 1'b1, 1'b0, 2'h2);
      wr = 1'b1;
      wd = 1'b0;
      @(negedge clk_sys);
      wr = 1'b0;
      chk(sec_fn_enable_ff, 1'b0);
      chk(sec_clk_run_ff, 1'b0);
      @(negedge clk_sys);
      chk(sec_lane_mask_ff, 16'h0000);
      chk(sec_link_train_en_ff, 1'b0);
      clk_en = 1'b0;
      wr = 1'b1;
      wd = 1'b1;
      @(negedge clk_sys);
      chk(sec_fn_enable_ff, 1'b0);
      clk_en = 1'b1;
      @(negedge clk_sys);
      wr = 1'b0;
      chk(sec_fn_enable_ff, 1'b1);
      chk(sec_clk_run_ff, 1'b1);
      @(negedge clk_sys);
      chk(sec_link_train_en_ff, 1'b1);
      chk(sec_lane_mask_ff, 16'hFF00);
      // firmware may drop the primary function in any configuration; checked here with both slots empty
      run_case(1'b0, 1'b0, 1'b0, 2'h0);
      pri_en = 1'b0;
      @(negedge clk_sys);
      chk(pri_clk_run_ff, 1'b0);
      pri_en = 1'b1;
      @(negedge clk_sys);
      chk(pri_clk_run_ff, 1'b1);
      $display("test_sec_write done");
   endtask : test_sec_write
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      // firmware side starts with the primary function enabled
      {rst, clk_en, pri_en, wr, wd} = 5'h1D;
      {pri_card, sec_card, lane_rev, failures, compares} = '0;
      test_straps();
      test_sec_write();
      end_of_test();
   end
endmodule : graphics_port_bifurcation_config_tb
